// File: src/compare_pick_map.svh
// Register offsets, command fields and reset values of the compare, pick and extract unit.
// Assumes inclusion by bare name wherever a constant below is needed.
`ifndef COMPARE_PICK_MAP_SVH
`define COMPARE_PICK_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_SRC_A_BOTTOM 8'h00
`define OFF_SRC_A_UPPER 8'h04
`define OFF_SRC_B_BOTTOM 8'h08
`define OFF_SRC_B_UPPER 8'h0C
`define OFF_SUM_WORD0 8'h10
`define OFF_SUM_WORD1 8'h14
`define OFF_SUM_WORD2 8'h18
`define OFF_SUM_WORD3 8'h1C
`define OFF_COMMAND 8'h20
`define OFF_RESULT_BOTTOM 8'h24
`define OFF_RESULT_UPPER 8'h28
`define OFF_PROC_CONTROL 8'h2C
`define OFF_STATUS 8'h30

// ****************************************
// Command and status fields
// ****************************************
`define CMD_OP_MSB 4
`define CMD_OP_LSB 0
`define CMD_VAR_MSB 9
`define CMD_VAR_LSB 8
`define CMD_SHIFT_MSB 20
`define CMD_SHIFT_LSB 16
`define STAT_WROTE_REG 0
`define STAT_WROTE_COND 1
`define STAT_BAD_OP 2

// ****************************************
// Constants
// ****************************************
`define COND_RESET 8'h00
`define SHIFT_IN_RIGHT_HIGH_BIAS 7'h20
`define Q31_MAX_64 64'h000000007FFFFFFF
`define WORD_BYTES 3'h4
`define DOUBLE_BYTES 4'h8

`endif

// File: src/compare_pick_pkg.sv
// Types shared by the compare, pick and extract unit.
// Assumes nothing beyond a SystemVerilog compiler.
package compare_pick_pkg;

	typedef enum logic [4:0]
	{
		compare_pair_halves,
		compare_quad_halves,
		compare_pair_words,
		unsigned_compare_flags,
		unsigned_compare_dual,
		unsigned_compare_reg,
		pick_quad_bytes,
		pick_octet_bytes,
		pick_pair_halves,
		pick_quad_halves,
		pick_pair_words,
		shift_in_left,
		shift_in_left_64,
		shift_in_right,
		shift_in_right_low_range,
		shift_in_right_high_range,
		byte_merge_32,
		byte_merge_64,
		element_pack_halves,
		element_pack_words,
		field_pull_word,
		wide_field_pull_word,
		wide_field_pull_double
	} op_t;

	typedef enum logic [1:0]
	{
		same_value_test,
		less_test,
		not_greater_test
	} cond_t;

	typedef enum logic [1:0]
	{
		field_pull_plain,
		field_pull_round,
		field_pull_round_sat
	} pull_t;

	typedef struct packed
	{
		logic [63:0] source_a;
		logic [63:0] source_b;
		logic [127:0] sum_holder;
		logic [7:0] signal_proc_control;
		logic [63:0] result;
		op_t op;
		logic [1:0] variant;
		logic [4:0] shift_count;
		logic wrote_reg;
		logic wrote_cond;
		logic bad_op;
		logic [31:0] rdata;
		logic slverr;
	} state_t;

endpackage

// File: src/compare_pick_unit.sv
// Compare, pick, shift-in, byte merge, pack and accumulator extract datapath behind an APB slave.
// Assumes an APB master on the same clock; a command write executes in the access cycle.
`timescale 1ns/1ps
`include "compare_pick_map.svh"

//
// Function
// [RL1] Compares offer equal, less, not-greater variants
// [RL2] Pair-halves signed compare sets two condition bits
// [RL3] Flag octet compare sets all eight bits
// [RL4] Dual octet compare writes register and flags
// [RL5] Register-only octet compare keeps condition bits
// [RL6] Quad-halves signed compare sets four bits
// [RL7] Pair-words signed compare sets two bits
// [RL8] Pick takes first source when bit set
// [RL9] Byte pick uses four or eight bits
// [RL10] Halfword and word picks use two/four bits
// [RL11] Word shift-in left/right, fill, sign-extend
// [RL12] Doubleword shift-in fills from other source
// [RL13] Low-range shift_in_right unbiased, high-range adds 32
// [RL14] Word byte merge, count from target
// [RL15] Doubleword byte merge, count from target
// [RL16] Halfword pack sign-extends, word pack plain
// [RL17] Word pull shifts 64-bit sum, sign-extends
// [RL18] Pulls offer plain, round, round-saturate
// [RL19] Saturating pull clamps to Q31 maximum
// [RL20] 64-bit sum built from both half words
// [RL21] Wide word pull from 128-bit sum
// [RL22] Wide doubleword pull with Q31 clamp
// [RL23] Untouched condition bits keep their values
module compare_pick_unit
#(
	parameter int ADDR_W = 12
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************
	// Elaboration check
	// ****************************************
	if (ADDR_W < 9)
	begin : g_bad_addr
		$error("ADDR_W must be at least 9");
	end

	compare_pick_pkg::state_t st_q;
	compare_pick_pkg::state_t st_d;

	function automatic logic [63:0] sext32(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction

	function automatic logic elem_test(input logic [32:0] x, input logic [32:0] y, input compare_pick_pkg::cond_t c);
		case (c)
			compare_pick_pkg::same_value_test: return x == y;
			compare_pick_pkg::less_test: return $signed(x) < $signed(y);
			compare_pick_pkg::not_greater_test: return $signed(x) <= $signed(y);
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************
	// Command decode
	// ****************************************
	logic [7:0] off;
	logic upper_zero;
	logic cmd_fire;
	compare_pick_pkg::op_t cmd_op;
	compare_pick_pkg::cond_t cnd;
	compare_pick_pkg::pull_t pull;
	logic [4:0] shamt;

	assign off = paddr[7:0];
	assign upper_zero = (paddr[ADDR_W-1:8] == '0);
	assign cmd_fire = psel && penable && pwrite && upper_zero && (off == `OFF_COMMAND);
	assign cmd_op = compare_pick_pkg::op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
	assign cnd = compare_pick_pkg::cond_t'(pwdata[`CMD_VAR_MSB:`CMD_VAR_LSB]);
	assign pull = compare_pick_pkg::pull_t'(pwdata[`CMD_VAR_MSB:`CMD_VAR_LSB]);
	assign shamt = pwdata[`CMD_SHIFT_MSB:`CMD_SHIFT_LSB];

	// ****************************************
	// Element lanes
	// ****************************************
	logic [7:0] byte_res;
	logic [3:0] half_res;
	logic [1:0] word_res;
	logic [63:0] pick_b;
	logic [63:0] pick_h;
	logic [63:0] pick_w;

	for (genvar i = 0; i < 8; i++)
	begin : g_lane
		// Bytes unsigned, halves and words signed
		assign byte_res[i] = elem_test({25'h0, st_q.source_a[8*i+:8]},
			{25'h0, st_q.source_b[8*i+:8]}, cnd); // see [RL1]
		assign pick_b[8*i+:8] = st_q.signal_proc_control[i] ? st_q.source_a[8*i+:8]
			: st_q.source_b[8*i+:8]; // see [RL8]
		if (i < 4)
		begin : g_half
			assign half_res[i] = elem_test({{17{st_q.source_a[16*i+15]}}, st_q.source_a[16*i+:16]},
				{{17{st_q.source_b[16*i+15]}}, st_q.source_b[16*i+:16]}, cnd);
			assign pick_h[16*i+:16] = st_q.signal_proc_control[i] ? st_q.source_a[16*i+:16]
				: st_q.source_b[16*i+:16]; // see [RL10]
		end
		if (i < 2)
		begin : g_word
			assign word_res[i] = elem_test({st_q.source_a[32*i+31], st_q.source_a[32*i+:32]},
				{st_q.source_b[32*i+31], st_q.source_b[32*i+:32]}, cnd);
			assign pick_w[32*i+:32] = st_q.signal_proc_control[i] ? st_q.source_a[32*i+:32]
				: st_q.source_b[32*i+:32]; // see [RL10]
		end
	end

	// ****************************************
	// Execution engine
	// ****************************************
	logic [63:0] ex_res;
	logic [7:0] ex_cond;
	logic ex_wr_reg;
	logic ex_wr_cond;
	logic ex_bad;
	logic ex_sat_hit;
	logic [127:0] pull_src;
	logic [127:0] pull_shift;
	logic [127:0] pull_rnd;
	logic [127:0] wide_tmp;
	logic [63:0] mask64;
	logic [4:0] shm1;
	logic rbit;

	always_comb
	begin
		ex_res = st_q.result;
		ex_cond = st_q.signal_proc_control;
		ex_wr_reg = 1'b0;
		ex_wr_cond = 1'b0;
		ex_bad = 1'b0;
		ex_sat_hit = 1'b0;
		wide_tmp = 128'h0;
		mask64 = (64'h0000000000000001 << shamt) - 64'h0000000000000001;
		// Sum halves: upper word sits in word 2, bottom word in word 0
		pull_src = (cmd_op == compare_pick_pkg::field_pull_word)
			? {64'h0, st_q.sum_holder[95:64], st_q.sum_holder[31:0]} : st_q.sum_holder; // see [RL20]
		pull_shift = pull_src >> shamt;
		shm1 = shamt - 5'h01;
		rbit = (shamt != 5'h00) && pull_src[shm1]; // see [RL18]
		pull_rnd = pull_shift + {127'h0, rbit};
		case (cmd_op)
			compare_pick_pkg::compare_pair_halves:
			begin
				ex_cond[1:0] = half_res[1:0]; // see [RL2] [RL23]
				ex_wr_cond = 1'b1;
			end
			compare_pick_pkg::compare_quad_halves:
			begin
				ex_cond[3:0] = half_res; // see [RL6] [RL23]
				ex_wr_cond = 1'b1;
			end
			compare_pick_pkg::compare_pair_words:
			begin
				ex_cond[1:0] = word_res; // see [RL7] [RL23]
				ex_wr_cond = 1'b1;
			end
			compare_pick_pkg::unsigned_compare_flags:
			begin
				ex_cond = byte_res; // see [RL3]
				ex_wr_cond = 1'b1;
			end
			compare_pick_pkg::unsigned_compare_dual:
			begin
				ex_cond = byte_res; // see [RL4]
				ex_res = {56'h0, byte_res};
				ex_wr_cond = 1'b1;
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::unsigned_compare_reg:
			begin
				ex_res = {56'h0, byte_res}; // see [RL5]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::pick_quad_bytes:
			begin
				ex_res = sext32(pick_b[31:0]); // see [RL9]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::pick_octet_bytes:
			begin
				ex_res = pick_b; // see [RL9]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::pick_pair_halves:
			begin
				ex_res = sext32(pick_h[31:0]); // see [RL10]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::pick_quad_halves:
			begin
				ex_res = pick_h;
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::pick_pair_words:
			begin
				ex_res = pick_w;
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::shift_in_left:
			begin
				ex_res = sext32((st_q.source_b[31:0] << shamt) | (st_q.source_a[31:0] & mask64[31:0])); // see [RL11]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::shift_in_left_64:
			begin
				ex_res = (st_q.source_b << shamt) | (st_q.source_a & mask64); // see [RL12]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::shift_in_right:
			begin
				wide_tmp = {64'h0, st_q.source_a[31:0], st_q.source_b[31:0]} >> shamt;
				ex_res = sext32(wide_tmp[31:0]); // see [RL11]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::shift_in_right_low_range:
			begin
				wide_tmp = {st_q.source_a, st_q.source_b} >> shamt; // see [RL12] [RL13]
				ex_res = wide_tmp[63:0];
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::shift_in_right_high_range:
			begin
				wide_tmp = {st_q.source_a, st_q.source_b} >> ({2'b00, shamt} + `SHIFT_IN_RIGHT_HIGH_BIAS); // see [RL13]
				ex_res = wide_tmp[63:0];
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::byte_merge_32:
			begin
				// Target bytes land on top, the other source fills the rest
				wide_tmp = {64'h0, st_q.source_b[31:0], st_q.source_a[31:0]}
					<< {(`WORD_BYTES - {1'b0, shamt[1:0]}), 3'b000}; // see [RL14]
				ex_res = sext32(wide_tmp[63:32]);
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::byte_merge_64:
			begin
				wide_tmp = {st_q.source_b, st_q.source_a}
					<< {(`DOUBLE_BYTES - {1'b0, shamt[2:0]}), 3'b000}; // see [RL15]
				ex_res = wide_tmp[127:64];
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::element_pack_halves:
			begin
				ex_res = {{32{st_q.source_a[15]}}, st_q.source_a[15:0], st_q.source_b[31:16]}; // see [RL16]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::element_pack_words:
			begin
				ex_res = {st_q.source_a[31:0], st_q.source_b[63:32]}; // see [RL16]
				ex_wr_reg = 1'b1;
			end
			compare_pick_pkg::field_pull_word, compare_pick_pkg::wide_field_pull_word:
			begin
				ex_wr_reg = 1'b1;
				ex_res = sext32(pull_shift[31:0]); // see [RL17] [RL21]
				if (pull != compare_pick_pkg::field_pull_plain)
				begin
					ex_res = sext32(pull_rnd[31:0]); // see [RL18]
				end
				ex_sat_hit = (pull == compare_pick_pkg::field_pull_round_sat) && !pull_shift[31] && pull_rnd[31];
				if (ex_sat_hit)
				begin
					ex_res = `Q31_MAX_64; // see [RL19]
				end
			end
			compare_pick_pkg::wide_field_pull_double:
			begin
				ex_wr_reg = 1'b1;
				ex_res = pull_shift[63:0]; // see [RL22]
				if (pull != compare_pick_pkg::field_pull_plain)
				begin
					ex_res = pull_rnd[63:0]; // see [RL18]
				end
				ex_sat_hit = (pull == compare_pick_pkg::field_pull_round_sat) && !pull_shift[63] && pull_rnd[63];
				if (ex_sat_hit)
				begin
					ex_res = `Q31_MAX_64; // see [RL22]
				end
			end
			default:
			begin
				ex_bad = 1'b1;
			end
		endcase
	end

	// ****************************************
	// Bus slave and state update
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		// Read data is caught in the setup cycle so prdata leaves a flop
		if (psel && !penable)
		begin
			st_d.slverr = !upper_zero;
			case (off)
				`OFF_SRC_A_BOTTOM: st_d.rdata = st_q.source_a[31:0];
				`OFF_SRC_A_UPPER: st_d.rdata = st_q.source_a[63:32];
				`OFF_SRC_B_BOTTOM: st_d.rdata = st_q.source_b[31:0];
				`OFF_SRC_B_UPPER: st_d.rdata = st_q.source_b[63:32];
				`OFF_SUM_WORD0: st_d.rdata = st_q.sum_holder[31:0];
				`OFF_SUM_WORD1: st_d.rdata = st_q.sum_holder[63:32];
				`OFF_SUM_WORD2: st_d.rdata = st_q.sum_holder[95:64];
				`OFF_SUM_WORD3: st_d.rdata = st_q.sum_holder[127:96];
				`OFF_COMMAND: st_d.rdata = {11'h000, st_q.shift_count, 6'h00, st_q.variant, 3'h0, st_q.op};
				`OFF_RESULT_BOTTOM:
				begin
					st_d.rdata = st_q.result[31:0];
					st_d.slverr = !upper_zero || pwrite;
				end
				`OFF_RESULT_UPPER:
				begin
					st_d.rdata = st_q.result[63:32];
					st_d.slverr = !upper_zero || pwrite;
				end
				`OFF_PROC_CONTROL: st_d.rdata = {24'h000000, st_q.signal_proc_control};
				`OFF_STATUS:
				begin
					st_d.rdata = {29'h0, st_q.bad_op, st_q.wrote_cond, st_q.wrote_reg};
					st_d.slverr = !upper_zero || pwrite;
				end
				default:
				begin
					st_d.rdata = 32'h00000000;
					st_d.slverr = 1'b1;
				end
			endcase
			if (!upper_zero)
			begin
				st_d.rdata = 32'h00000000;
			end
		end
		// Writes take effect only at the access edge and only if not refused
		if (psel && penable && pwrite && !st_q.slverr)
		begin
			case (off)
				`OFF_SRC_A_BOTTOM: st_d.source_a[31:0] = pwdata;
				`OFF_SRC_A_UPPER: st_d.source_a[63:32] = pwdata;
				`OFF_SRC_B_BOTTOM: st_d.source_b[31:0] = pwdata;
				`OFF_SRC_B_UPPER: st_d.source_b[63:32] = pwdata;
				`OFF_SUM_WORD0: st_d.sum_holder[31:0] = pwdata;
				`OFF_SUM_WORD1: st_d.sum_holder[63:32] = pwdata;
				`OFF_SUM_WORD2: st_d.sum_holder[95:64] = pwdata;
				`OFF_SUM_WORD3: st_d.sum_holder[127:96] = pwdata;
				`OFF_PROC_CONTROL: st_d.signal_proc_control = pwdata[7:0];
				`OFF_COMMAND:
				begin
					st_d.op = cmd_op;
					st_d.variant = pwdata[`CMD_VAR_MSB:`CMD_VAR_LSB];
					st_d.shift_count = shamt;
					st_d.result = ex_res;
					st_d.signal_proc_control = ex_cond;
					st_d.wrote_reg = ex_wr_reg;
					st_d.wrote_cond = ex_wr_cond;
					st_d.bad_op = ex_bad;
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.rdata;
	assign pslverr = st_q.slverr;
	assign pready = 1'b1;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	logic fire_ok;
	assign fire_ok = cmd_fire && !st_q.slverr;

	property p_pair_halves_keeps_rest;
		fire_ok && cmd_op == compare_pick_pkg::compare_pair_halves |=>
			st_q.signal_proc_control[7:2] == $past(st_q.signal_proc_control[7:2]) && st_q.result == $past(st_q.result);
	endproperty
	a_pair_halves_keeps_rest: assert property (p_pair_halves_keeps_rest) else $error("pair halves compare disturbed state"); // see [RL2]

	property p_flags_octet_less;
		fire_ok && cmd_op == compare_pick_pkg::unsigned_compare_flags && cnd == compare_pick_pkg::less_test |=>
			st_q.signal_proc_control[0] == ($past(st_q.source_a[7:0]) < $past(st_q.source_b[7:0]))
			&& st_q.signal_proc_control[7] == ($past(st_q.source_a[63:56]) < $past(st_q.source_b[63:56]));
	endproperty
	a_flags_octet_less: assert property (p_flags_octet_less) else $error("octet flag compare wrong"); // see [RL3]

	property p_dual_matches;
		fire_ok && cmd_op == compare_pick_pkg::unsigned_compare_dual |=>
			st_q.result == {56'h0, st_q.signal_proc_control} && st_q.wrote_cond && st_q.wrote_reg;
	endproperty
	a_dual_matches: assert property (p_dual_matches) else $error("dual compare outputs differ"); // see [RL4]

	property p_reg_only_keeps_flags;
		fire_ok && cmd_op == compare_pick_pkg::unsigned_compare_reg |=>
			$stable(st_q.signal_proc_control) && st_q.result[63:8] == 56'h0;
	endproperty
	a_reg_only_keeps_flags: assert property (p_reg_only_keeps_flags) else $error("register-only compare touched flags"); // see [RL5]

	property p_quad_halves_equal;
		fire_ok && cmd_op == compare_pick_pkg::compare_quad_halves && cnd == compare_pick_pkg::same_value_test |=>
			st_q.signal_proc_control[3] == ($past(st_q.source_a[63:48]) == $past(st_q.source_b[63:48]))
			&& st_q.signal_proc_control[7:4] == $past(st_q.signal_proc_control[7:4]);
	endproperty
	a_quad_halves_equal: assert property (p_quad_halves_equal) else $error("quad halves compare wrong"); // see [RL6]

	property p_pick_octet_lane1;
		fire_ok && cmd_op == compare_pick_pkg::pick_octet_bytes |=>
			st_q.result[15:8] == ($past(st_q.signal_proc_control[1]) ? $past(st_q.source_a[15:8])
			: $past(st_q.source_b[15:8]));
	endproperty
	a_pick_octet_lane1: assert property (p_pick_octet_lane1) else $error("byte pick chose wrong source"); // see [RL8]

	property p_shift_left_zero;
		fire_ok && cmd_op == compare_pick_pkg::shift_in_left && shamt == 5'h00 |=>
			st_q.result == sext32($past(st_q.source_b[31:0]));
	endproperty
	a_shift_left_zero: assert property (p_shift_left_zero) else $error("zero shift-in left altered target"); // see [RL11]

	property p_high_range_bias;
		fire_ok && cmd_op == compare_pick_pkg::shift_in_right_high_range && shamt == 5'h00 |=>
			st_q.result == {$past(st_q.source_a[31:0]), $past(st_q.source_b[63:32])};
	endproperty
	a_high_range_bias: assert property (p_high_range_bias) else $error("high-range shift_in_right bias wrong"); // see [RL13]

	property p_pack_words;
		fire_ok && cmd_op == compare_pick_pkg::element_pack_words |=>
			st_q.result == {$past(st_q.source_a[31:0]), $past(st_q.source_b[63:32])};
	endproperty
	a_pack_words: assert property (p_pack_words) else $error("word pack wrong"); // see [RL16]

	property p_word_pull_sext;
		fire_ok && cmd_op == compare_pick_pkg::field_pull_word |=> st_q.result[63:32] == {32{st_q.result[31]}};
	endproperty
	a_word_pull_sext: assert property (p_word_pull_sext) else $error("word pull not sign-extended"); // see [RL17]

	property p_sat_clamp;
		fire_ok && ex_sat_hit |=> st_q.result == `Q31_MAX_64 ##1 st_q.wrote_reg;
	endproperty
	a_sat_clamp: assert property (p_sat_clamp) else $error("saturating pull did not clamp"); // see [RL19]

endmodule

// File: tb/apb_host.sv
// APB master model standing in for the processor side of the unit.
// Assumes one clock and a slave that may add wait states.
`timescale 1ns/1ps
module apb_host
(
	input wire logic clock,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// ****
	// One transfer; request held until pready is seen high
	// ****
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the compare, pick and extract unit.
// Assumes the unit's register map header; all traffic goes through the host model.
`timescale 1ns/1ps
`include "compare_pick_map.svh"
module tb_top;
	logic clock;
	logic arst_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rv;
	logic re;
	logic [63:0] r64;
	int err_count;
	int n_tests;
	// Compares: op, variant, condition bits, result byte, status
	// Last three: quad halves equal, the all-false variant and an unknown op code
	logic [25:0] ctab [11] = '{{5'h00, 2'h0, 8'hFE, 8'h00, 3'h2}, {5'h00, 2'h1, 8'hFD, 8'h00, 3'h2},
		{5'h00, 2'h2, 8'hFF, 8'h00, 3'h2}, {5'h01, 2'h1, 8'hF9, 8'h00, 3'h2}, {5'h02, 2'h1, 8'hFA, 8'h00, 3'h2},
		{5'h03, 2'h1, 8'h40, 8'h00, 3'h2}, {5'h04, 2'h2, 8'h7C, 8'h7C, 3'h3}, {5'h05, 2'h0, 8'h7C, 8'h3C, 3'h1},
		{5'h01, 2'h0, 8'h76, 8'h3C, 3'h2}, {5'h00, 2'h3, 8'h74, 8'h3C, 3'h2}, {5'h17, 2'h0, 8'h74, 8'h3C, 3'h4}};
	// Picks, shift-ins, merges, packs: op, count, result
	logic [73:0] ptab [19] = '{{5'h07, 5'h00, 64'hA1B2A3B4_B5A6B7A8}, {5'h06, 5'h00, 64'hFFFFFFFF_B5A6B7A8},
		{5'h08, 5'h00, 64'hFFFFFFFF_B5B6A7A8}, {5'h09, 5'h00, 64'hB1B2A3A4_B5B6A7A8},
		{5'h0A, 5'h00, 64'hB1B2B3B4_A5A6A7A8}, {5'h0B, 5'h08, 64'hFFFFFFFF_B6B7B8A8},
		{5'h0B, 5'h1F, 64'h00000000_25A6A7A8}, {5'h0C, 5'h08, 64'hB2B3B4B5_B6B7B8A8},
		{5'h0D, 5'h08, 64'hFFFFFFFF_A8B5B6B7}, {5'h0E, 5'h08, 64'hA8B1B2B3_B4B5B6B7},
		{5'h0E, 5'h00, 64'hB1B2B3B4_B5B6B7B8}, {5'h0F, 5'h08, 64'hA4A5A6A7_A8B1B2B3},
		{5'h0F, 5'h00, 64'hA5A6A7A8_B1B2B3B4}, {5'h10, 5'h00, 64'hFFFFFFFF_A5A6A7A8},
		{5'h10, 5'h03, 64'hFFFFFFFF_B6B7B8A5}, {5'h11, 5'h03, 64'hB6B7B8A1_A2A3A4A5},
		{5'h12, 5'h00, 64'hFFFFFFFF_A7A8B5B6}, {5'h13, 5'h00, 64'hA5A6A7A8_B1B2B3B4},
		{5'h0B, 5'h00, 64'hFFFFFFFF_B5B6B7B8}};
	// Pulls: sum set, op, variant, shift, result
	logic [76:0] qtab [9] = '{{1'h0, 5'h14, 2'h0, 5'h04, 64'h00000000_23456789},
		{1'h0, 5'h14, 2'h1, 5'h04, 64'h00000000_2345678A}, {1'h0, 5'h15, 2'h0, 5'h04, 64'hFFFFFFFF_B3456789},
		{1'h0, 5'h15, 2'h2, 5'h04, 64'hFFFFFFFF_B345678A}, {1'h0, 5'h16, 2'h1, 5'h04, 64'h2000000A_B345678A},
		{1'h1, 5'h14, 2'h1, 5'h01, 64'hFFFFFFFF_80000000}, {1'h1, 5'h14, 2'h2, 5'h01, 64'h00000000_7FFFFFFF},
		{1'h1, 5'h16, 2'h2, 5'h01, 64'h00000000_7FFFFFFF}, {1'h1, 5'h16, 2'h0, 5'h01, 64'h7FFFFFFF_FFFFFFFF}};
	// Word 1 is nonzero and differs from word 2, so a wrong half choice shows
	logic [127:0] sums [2] = '{128'h00000000_00000012_000000AB_34567898, 128'h00000000_00000000_FFFFFFFF_FFFFFFFF};

	apb_host bus
	(
		.clock(clock),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	compare_pick_unit dut
	(
		.clock(clock),
		.arst_n(arst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ****
	// Access and compare helpers
	// ****
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus.xfer(1'b1, {4'h0, a}, d, rv, re);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus.xfer(1'b0, {4'h0, a}, 32'h00000000, q, re);
	endtask

	task automatic wr64(input logic [7:0] a, input logic [63:0] v);
		wr(a, v[31:0]);
		wr(a + 8'h04, v[63:32]);
	endtask

	task automatic res(output logic [63:0] r);
		logic [31:0] lo;
		logic [31:0] hi;
		rd(`OFF_RESULT_BOTTOM, lo);
		rd(`OFF_RESULT_UPPER, hi);
		r = {hi, lo};
	endtask

	task automatic cmd(input logic [4:0] o, input logic [1:0] v, input logic [4:0] s);
		wr(`OFF_COMMAND, {11'h000, s, 6'h00, v, 3'h0, o});
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask

	task automatic close_out();
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever
			#4 clock = ~clock;
	end

	// Whole run needs under 600 cycles; this margin only cuts a hang
	initial
	begin
		#100000;
		err_count++;
		close_out();
	end

	// ****
	// Test sequence
	// ****
	initial
	begin
		err_count = 0;
		n_tests = 0;
		arst_n = 1'b0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		rd(`OFF_PROC_CONTROL, rv);
		chk("cond after reset", 64'h0, {32'h0, rv});
		wr64(`OFF_SRC_A_BOTTOM, 64'h80000001_0005FFFF);
		wr64(`OFF_SRC_B_BOTTOM, 64'h7FFF0001_00050001);
		wr(`OFF_PROC_CONTROL, 32'h000000FF);
		foreach (ctab[i])
		begin
			cmd(ctab[i][25:21], ctab[i][20:19], 5'h00);
			rd(`OFF_PROC_CONTROL, rv);
			chk("cond bits", {56'h0, ctab[i][18:11]}, {32'h0, rv});
			res(r64);
			chk("compare result", {56'h0, ctab[i][10:3]}, r64);
			rd(`OFF_STATUS, rv);
			chk("status", {61'h0, ctab[i][2:0]}, {32'h0, rv});
		end
		wr64(`OFF_SRC_A_BOTTOM, 64'hA1A2A3A4_A5A6A7A8);
		wr64(`OFF_SRC_B_BOTTOM, 64'hB1B2B3B4_B5B6B7B8);
		wr(`OFF_PROC_CONTROL, 32'h000000A5);
		foreach (ptab[i])
		begin
			cmd(ptab[i][73:69], 2'h0, ptab[i][68:64]);
			res(r64);
			chk("datapath result", ptab[i][63:0], r64);
		end
		foreach (qtab[i])
		begin
			wr64(`OFF_SUM_WORD0, sums[qtab[i][76]][63:0]);
			wr64(`OFF_SUM_WORD2, sums[qtab[i][76]][127:64]);
			cmd(qtab[i][75:71], qtab[i][70:69], qtab[i][68:64]);
			res(r64);
			chk("pull result", qtab[i][63:0], r64);
		end
		rd(`OFF_COMMAND, rv);
		chk("command readback", 64'h00000000_00010016, {32'h0, rv});
		wr(`OFF_RESULT_BOTTOM, 32'h00000000);
		chk("result write error", 64'h0000000000000001, {63'h0, re});
		res(r64);
		chk("result after refused write", 64'h7FFFFFFF_FFFFFFFF, r64);
		rd(8'h34, rv);
		chk("unmapped read", 64'h00000001_00000000, {31'h0, re, rv});
		close_out();
	end
endmodule
